// ===== src/sac_device.sv
// module: converter end, starts conversions and drives the result bus
`default_nettype none
// ---------------------------------------------------------------------------
// converter end
// ---------------------------------------------------------------------------
// Notes on behaviour
// - host holds convert low 40ns to 7us
// - busy low from start until result refreshed
// - result is 16-bit two's complement, msb top
// - convert commands ignored while busy low
// - busy rising edge strobes the new result
// - tracking resumes at end; space commands 10us
// - both lines low starts conversion, hold
// - host releases a line before busy rises
// - chip select and convert ORed, level sensitive
// - non-trigger input low 10ns earlier
// - select tied low: bus driven while read high
// - select high: no operation, bus released
// - select falls, convert low: start, bus off
// - convert falls, select low: start, bus off
// - idle read shows result of conversion n
// - select falls with read high: bus enabled
// - reading during conversion shows result n-1
module sac_device #(
	parameter int unsigned CONV_CYCLES = sac_pkg::CONVT_CYC
) (
	input  wire logic        mclk,
	input  wire logic        resetn,
	sac_if.device            link,
	input  wire logic [15:0] sample_in,
	output var  logic        sample_hold,
	output var  logic        conv_done
);
	// ---------------------------------------------------------------
	// local constants and types
	// ---------------------------------------------------------------
	localparam int unsigned      CNT_W      = sac_pkg::CNT_W;
	// counter reload; the span lasts CONV_CYCLES cycles, so zero is not a usable length
	localparam logic [CNT_W-1:0] COUNT_LOAD = CNT_W'(CONV_CYCLES - 1);
	localparam logic [CNT_W-1:0] COUNT_LAST = '0;

	// one-hot phase of the converter core
	typedef enum logic [1:0] {
		SAC_TRACK   = 2'h1, // input followed, sample and hold open
		SAC_CONVERT = 2'h2  // sample held, span counter running
	} sac_phase_t;

	// ---------------------------------------------------------------
	// decoding helpers
	// ---------------------------------------------------------------
	// level-sensitive start: both lines low while tracking, whichever fell first
	function automatic logic start_req(
		input sac_phase_t ph,
		input logic       cs_low,
		input logic       rc_low
	);
		return (ph == SAC_TRACK) && cs_low && rc_low;
	endfunction : start_req

	// last cycle of the span: the result register is refreshed here
	function automatic logic span_last(
		input sac_phase_t       ph,
		input logic [CNT_W-1:0] cnt
	);
		return (ph == SAC_CONVERT) && (cnt == COUNT_LAST);
	endfunction : span_last

	// bus enable: selected and in read mode; any other pair releases the bus
	function automatic logic read_enable(
		input logic cs_low,
		input logic rc_high
	);
		return cs_low && rc_high;
	endfunction : read_enable

	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic             cs_s;    // synchronised chip select, active low
	logic             rc_s;    // synchronised read/convert
	sac_phase_t       phase;   // converter phase
	logic             busy;    // conversion in progress
	logic [CNT_W-1:0] count;   // cycles left in the span
	logic [15:0]      result;  // result register, conversion n-1 until refreshed
	logic             start;   // start accepted this cycle
	logic             last;    // final span cycle
	logic             read_on; // bus enable request

	// ---------------------------------------------------------------
	// control line synchronisers
	// ---------------------------------------------------------------
	// idle level is high on both lines, so no false start follows reset
	sac_sync #(
		.INIT   (1'b1)
	) u_cs (
		.mclk   (mclk),
		.resetn (resetn),
		.d      (link.cs_n),
		.q      (cs_s)
	);

	sac_sync #(
		.INIT   (1'b1)
	) u_rc (
		.mclk   (mclk),
		.resetn (resetn),
		.d      (link.rc),
		.q      (rc_s)
	);

	// ---------------------------------------------------------------
	// start and end decoding
	// ---------------------------------------------------------------
	// commands while converting fail the phase test and are ignored
	assign busy    = phase == SAC_CONVERT;
	assign start   = start_req(phase, !cs_s, !rc_s);
	assign last    = span_last(phase, count);
	assign read_on = read_enable(!cs_s, rc_s);

	// ---------------------------------------------------------------
	// conversion phase and span counter
	// ---------------------------------------------------------------
	// a start still held when the span ends re-triggers at once; that
	// conversion has no fresh sample, so the host must release a line first
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			phase <= SAC_TRACK;
		end
		else if (start)
		begin
			phase <= SAC_CONVERT;
		end
		else if (last)
		begin
			phase <= SAC_TRACK; // released on the same edge as the result update
		end
	end

	// span counter: loaded at start, counts down to the last cycle
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			count <= COUNT_LAST;
		end
		else if (start)
		begin
			count <= COUNT_LOAD;
		end
		else if (busy && count != COUNT_LAST)
		begin
			count <= count - 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// sample, result and completion
	// ---------------------------------------------------------------
	// sample and hold: held from start, tracking again once the span ends
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			sample_hold <= 1'b0;
		end
		else if (start)
		begin
			sample_hold <= 1'b1;
		end
		else if (last)
		begin
			sample_hold <= 1'b0; // tracking again
		end
	end

	// result refreshed on the last cycle only, so reads in flight see n-1
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			result <= sac_pkg::RESULT_RESET;
		end
		else if (last)
		begin
			result <= sample_in; // two's complement passed straight through
		end
	end

	// completion pulse, one cycle, in step with the busy release
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			conv_done <= 1'b0;
		end
		else
		begin
			conv_done <= last;
		end
	end

	// ---------------------------------------------------------------
	// link outputs
	// ---------------------------------------------------------------
	// busy low from the start edge through the last span cycle; it rises on the
	// edge that presents the new word, so the host may strobe on that edge
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			link.busy_n <= 1'b1;
		end
		else
		begin
			link.busy_n <= !(start || (busy && !last));
		end
	end

	// bus enable from the synchronised lines; three cycles behind the pins
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			link.result_oe <= 1'b0;
		end
		else
		begin
			link.result_oe <= read_on;
		end
	end

	// drive word: the fresh result on the last cycle, the kept one otherwise
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			link.result_out <= sac_pkg::RESULT_RESET;
		end
		else
		begin
			link.result_out <= last ? sample_in : result;
		end
	end
endmodule : sac_device
`default_nettype wire

// ===== src/sac_pkg.sv
// package: shared widths and timing constants for the converter control link
`default_nettype none
package sac_pkg;
	localparam int unsigned DATA_W        = 16;
	localparam int unsigned CLK_NS        = 20;
	// host convert pulse: least 40 ns, longest 7 us
	localparam int unsigned CONV_MIN_NS   = 40;
	localparam int unsigned CONV_MAX_NS   = 7000;
	localparam int unsigned CONV_MIN_CYC  = (CONV_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned CONV_MAX_CYC  = CONV_MAX_NS / CLK_NS;
	// spacing between convert commands: least 10 us
	localparam int unsigned SPACE_NS      = 10000;
	localparam int unsigned SPACE_CYC     = (SPACE_NS + CLK_NS - 1) / CLK_NS;
	// setup of the non-triggering input: least 10 ns
	localparam int unsigned SETUP_NS      = 10;
	localparam int unsigned SETUP_CYC     = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	// conversion span, default 8 us
	localparam int unsigned CONVT_NS      = 8000;
	localparam int unsigned CONVT_CYC     = CONVT_NS / CLK_NS;
	localparam int unsigned CNT_W         = 10;
	localparam logic [15:0] RESULT_RESET  = 16'h0000;
	localparam logic [15:0] SAMPLE_STEP   = 16'h0001;
endpackage : sac_pkg
`default_nettype wire

// ===== src/sac_if.sv
// interface: control lines, busy flag and three-state result bus
`default_nettype none
interface sac_if;
	logic        cs_n;       // chip select, active low
	logic        rc;         // read high, convert low
	logic        busy_n;     // conversion in progress, active low
	logic [15:0] result_out; // device drive value
	logic        result_oe;  // device drive enable
	logic [15:0] result_bus; // resolved bus level
	// a released bus shows the inverse of the last word, so a read of a released bus cannot pass
	assign result_bus = result_oe ? result_out : ~result_out;
	modport device (input cs_n, input rc, output busy_n, output result_out, output result_oe);
	modport host (output cs_n, output rc, input busy_n, input result_bus, input result_oe);
endinterface : sac_if
`default_nettype wire

// ===== src/sac_sync.sv
// module: two-flop synchroniser for single-bit inputs
`default_nettype none
module sac_sync #(
	parameter logic INIT = 1'b1
) (
	input  wire logic mclk,
	input  wire logic resetn,
	input  wire logic d,
	output var  logic q
);
	logic stage1;

	// first flop is read only by the second
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			stage1 <= INIT;
			q      <= INIT;
		end
		else
		begin
			stage1 <= d;
			q      <= stage1;
		end
	end
endmodule : sac_sync
`default_nettype wire

// ===== src/sac_host.sv
// module: host end, pulses the control lines and latches results
`default_nettype none
module sac_host (
	input  wire logic        mclk,
	input  wire logic        resetn,
	sac_if.host              link,
	input  wire logic        convert_req,
	input  wire logic        use_cs,
	output var  logic        req_ready,
	output var  logic [15:0] data_out,
	output var  logic        data_valid
);
	typedef enum logic [3:0] {
		SAC_IDLE  = 4'b0001,
		SAC_SETUP = 4'b0010,
		SAC_PULSE = 4'b0100,
		SAC_WAIT  = 4'b1000
	} sac_state_t;

	sac_state_t                state;
	logic [9:0]                timer;
	logic [9:0]                space;
	logic                      busy_s;
	logic                      busy_d;
	logic [15:0]               bus_s1;
	logic [15:0]               bus_s2;

	sac_sync #(.INIT(1'b1)) u_busy (.mclk(mclk), .resetn(resetn), .d(link.busy_n), .q(busy_s));

	// bus word through two flops before capture
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			bus_s1 <= sac_pkg::RESULT_RESET;
			bus_s2 <= sac_pkg::RESULT_RESET;
		end
		else
		begin
			bus_s1 <= link.result_bus;
			bus_s2 <= bus_s1;
		end
	end

	// sequence: setup other line, pulse trigger, release before busy rises
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state     <= SAC_IDLE;
			timer     <= '0;
			link.cs_n <= 1'b1;
			link.rc   <= 1'b1;
			req_ready <= 1'b0;
		end
		else
		begin
			case (state)
				SAC_IDLE:
				begin
					link.cs_n <= 1'b0; // read mode while idle
					link.rc   <= 1'b1;
					req_ready <= space == '0;
					if (convert_req && space == '0)
					begin
						req_ready <= 1'b0;
						if (use_cs)
						begin
							link.cs_n <= 1'b1;
							link.rc   <= 1'b0; // rc low first, cs triggers
						end
						timer <= 10'(sac_pkg::SETUP_CYC);
						state <= SAC_SETUP;
					end
				end
				SAC_SETUP:
				begin
					if (timer == '0)
					begin
						link.cs_n <= 1'b0;
						link.rc   <= 1'b0;
						timer     <= 10'(sac_pkg::CONV_MIN_CYC);
						state     <= SAC_PULSE;
					end
					else
						timer <= timer - 1'b1;
				end
				SAC_PULSE:
				begin
					if (timer == '0)
					begin
						link.rc <= 1'b1; // pulse within 40ns..7us
						state   <= SAC_WAIT;
					end
					else
						timer <= timer - 1'b1;
				end
				SAC_WAIT:
				begin
					if (busy_s && !busy_d && timer == '0)
						state <= SAC_IDLE;
					if (!busy_s)
						timer <= '0;
				end
				default:
					state <= SAC_IDLE;
			endcase
		end
	end

	// busy rising edge latches result, spacing counter enforces 10us
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			busy_d     <= 1'b1;
			data_out   <= sac_pkg::RESULT_RESET;
			data_valid <= 1'b0;
			space      <= '0;
		end
		else
		begin
			busy_d     <= busy_s;
			data_valid <= 1'b0;
			if (state == SAC_SETUP && timer == '0)
				space <= 10'(sac_pkg::SPACE_CYC);
			else if (space != '0)
				space <= space - 1'b1;
			if (state == SAC_WAIT && busy_s && !busy_d)
			begin
				data_out   <= bus_s2;
				data_valid <= 1'b1;
			end
		end
	end
endmodule : sac_host
`default_nettype wire

// ===== bench/sac_assertions.sv
// checker: control lines, busy flag and result drive
`default_nettype none
module sac_assertions #(
	parameter int unsigned CONV_CYCLES = sac_pkg::CONVT_CYC
) (
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic        cs_n,
	input wire logic        rc,
	input wire logic        busy_n,
	input wire logic [15:0] result_out,
	input wire logic        result_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] low_cnt;
	logic        both_low;
	// start request seen at the pins
	assign both_low = !cs_n && !rc;
	// length of the current busy span, so the full count is checked, not just a few cycles
	always_ff @(posedge mclk or negedge resetn)
		if (!resetn)
			low_cnt <= 16'h0000;
		else
			low_cnt <= busy_n ? 16'h0000 : low_cnt + 16'h0001;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	busy_len_a: assert property ($rose(busy_n) |-> {16'h0000, low_cnt} == CONV_CYCLES)
		else $error("busy span length wrong");
	busy_ignore_a: assert property ($fell(busy_n) |=> !busy_n [*8])
		else $error("busy ended early");
	busy_cause_a: assert property ($fell(busy_n) |->
		$past(both_low, 2) || $past(both_low, 3) || $past(both_low, 4))
		else $error("busy fell without start");
	busy_rest_a: assert property ($rose(busy_n) |-> busy_n [*4])
		else $error("busy restarted at once");
	result_hold_a: assert property (!$rose(busy_n) |-> $stable(result_out))
		else $error("result changed outside busy end");
	oe_idle_off_a: assert property ($past(cs_n, 3) |-> !result_oe)
		else $error("bus driven while deselected");
	oe_conv_off_a: assert property ($past(both_low, 3) |-> !result_oe)
		else $error("bus driven while converting");
	oe_read_on_a: assert property ((!cs_n && rc) [*4] |-> result_oe)
		else $error("bus not driven in read");
	oe_rise_a: assert property ($rose(result_oe) |-> !$past(cs_n, 3) && $past(rc, 3))
		else $error("bus enabled without read");
endmodule : sac_assertions
`default_nettype wire

// ===== bench/sar_adc_convert_read_control_tb_top.sv
// testbench: both converter ends joined, conversions commanded from the host side
`default_nettype none
module sar_adc_convert_read_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned CONV = 20; // short span keeps the run brief
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic [15:0] sample_in = 16'h0000;
	logic        convert_req = 1'b0;
	logic        use_cs = 1'b0;
	logic        sample_hold;
	logic        conv_done;
	logic        req_ready;
	logic        data_valid;
	logic [15:0] data_out;
	int          errors = 0;
	int          checked = 0;
	int          cycles = 0;
	sac_if link ();
	sac_device #(.CONV_CYCLES(CONV)) i_sac_device (.mclk(mclk), .resetn(resetn),
		.link(link), .sample_in(sample_in), .sample_hold(sample_hold), .conv_done(conv_done));
	sac_host i_sac_host (.mclk(mclk), .resetn(resetn), .link(link),
		.convert_req(convert_req), .use_cs(use_cs), .req_ready(req_ready),
		.data_out(data_out), .data_valid(data_valid));
	sac_assertions #(.CONV_CYCLES(CONV)) i_sac_assertions (.mclk(mclk), .resetn(resetn),
		.cs_n(link.cs_n), .rc(link.rc), .busy_n(link.busy_n),
		.result_out(link.result_out), .result_oe(link.result_oe));
	// compare one value, four-state so an unknown never matches
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic summarize();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	// one conversion: old word readable while busy, new word latched and driven after
	task automatic t_convert(input logic by_cs, input logic [15:0] val, input logic [15:0] prev);
		for (int n = 0; n < 1000 && req_ready !== 1'b1; n++) @(negedge mclk);
		chk({15'h0000, req_ready}, 16'h0001);
		use_cs = by_cs;
		sample_in = val;
		convert_req = 1'b1;
		@(negedge mclk);
		convert_req = 1'b0;
		for (int n = 0; n < 20 && link.busy_n !== 1'b0; n++) @(negedge mclk);
		chk({15'h0000, link.busy_n}, 16'h0000);
		chk({15'h0000, sample_hold}, 16'h0001);
		repeat (8) @(negedge mclk);
		chk(link.result_bus, prev);
		chk({15'h0000, link.busy_n}, 16'h0000);
		for (int n = 0; n < 40 && link.busy_n !== 1'b1; n++) @(negedge mclk);
		chk({14'h0000, conv_done, sample_hold}, 16'h0002);
		chk(link.result_bus, val);
		for (int n = 0; n < 60 && data_valid !== 1'b1; n++) @(negedge mclk);
		chk(data_out, val);
		repeat (4) @(negedge mclk);
		chk(link.result_bus, val);
		$display("conversion test done, cs trigger %0b", by_cs);
	endtask : t_convert
	// reset, at start and in mid-run: read mode shows the reset word once synchronised
	task automatic t_reset();
		resetn = 1'b0;
		repeat (6) @(negedge mclk);
		resetn = 1'b1;
		repeat (8) @(negedge mclk);
		chk(link.result_bus, 16'h0000);
		chk({15'h0000, link.busy_n}, 16'h0001);
		$display("reset test done");
	endtask : t_reset
	// free-running clock, 20 ns period
	always #10 mclk = ~mclk;
	// hang guard: four conversions and two resets need about 1100 cycles
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 6000)
		begin
			errors++;
			summarize();
		end
	end
	// main sequence: both triggers, boundary codes of the two's complement range
	initial
	begin
		t_reset();
		t_convert(1'b0, 16'h8000, 16'h0000);
		t_convert(1'b1, 16'h7fff, 16'h8000);
		t_convert(1'b0, 16'hffff, 16'h7fff);
		t_reset();
		t_convert(1'b1, 16'h0001, 16'h0000);
		summarize();
	end
endmodule : sar_adc_convert_read_control_tb_top
`default_nettype wire
